// ==== design/gain_seg_regs.sv ====
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module gain_seg_regs (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // wishbone classic slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic [31:0]                    wb_dat_o,
    output logic                           wb_ack_o,
    // calibration engine
    input  wire logic                      cal_done,
    input  wire logic [7:0]                seg_cal_word_a,
    input  wire logic [7:0]                seg_cal_word_b,
    input  wire logic [7:0]                seg_cal_word_c,
    // amplitude estimate for ranging
    input  wire logic                      amp_valid,
    input  wire logic [12:0]               amp_level,
    // front-end gain control
    output gain_seg_pkg::gain_seg_type     range_gain,
    output logic                           auto_range,
    // converter samples and corrected result
    input  wire logic                      adc_valid,
    input  wire logic [12:0]               adc_data,
    input  gain_seg_pkg::gain_seg_type     adc_seg,
    output logic                           corr_valid,
    output logic [12:0]                    corr_data
);
    import gain_seg_pkg::*;

    logic [7:0]   cal_r [NUM_CAL];
    logic [7:0]   cal_in [NUM_CAL];
    logic [2:0]   forced_amp_sel_r;
    logic         ack_r;
    logic [31:0]  dat_r;
    gain_seg_type range_gain_r;
    gain_seg_type range_gain_nxt;
    logic         auto_range_r;

    logic         req;
    logic         wr_fire;
    logic         aligned;
    logic [5:0]   idx;
    logic         hit_a;
    logic         hit_b;
    logic         hit_c;
    logic         hit_ctrl;
    logic [7:0]   ctrl_rd;
    logic [7:0]   rd_byte;
    logic         sel_auto;
    gain_seg_type forced_gain;
    gain_seg_type auto_pick;

    // bus decode
    assign req      = wb_cyc_i & wb_stb_i;
    assign aligned  = (wb_adr_i[1:0] == 2'b00);
    assign idx      = wb_adr_i[7:2];
    assign hit_a    = aligned & (idx == IDX_CAL_A);
    assign hit_b    = aligned & (idx == IDX_CAL_B);
    assign hit_c    = aligned & (idx == IDX_CAL_C);
    assign hit_ctrl = aligned & (idx == IDX_FORCED);
    // writes land on the edge where the master sees ack
    assign wr_fire  = req & wb_we_i & ack_r;

    assign ctrl_rd  = {2'b00, forced_amp_sel_r, 3'b000};   // R10
    assign rd_byte  = hit_a    ? cal_r[0] :
                      hit_b    ? cal_r[1] :
                      hit_c    ? cal_r[2] :
                      hit_ctrl ? ctrl_rd  : 8'h00;

    assign cal_in[0] = seg_cal_word_a;
    assign cal_in[1] = seg_cal_word_b;
    assign cal_in[2] = seg_cal_word_c;

    // one cycle of wait state; ack drops the cycle after it rose
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= req & ~ack_r;
            if (req & ~ack_r & ~wb_we_i) begin
                dat_r <= {24'h000000, rd_byte};
            end
        end
    end

    // offsets only change when calibration finishes; bus writes are
    // dropped so a stray write cannot lose the calibrated values
    for (genvar g = 0; g < NUM_CAL; g++) begin : g_cal
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                cal_r[g] <= CAL_RESET;   // R1
            end else if (cal_done) begin
                cal_r[g] <= cal_in[g];   // R3
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            forced_amp_sel_r <= CTRL_RESET[SEL_MSB:SEL_LSB];   // R6
        end else if (wr_fire & hit_ctrl & wb_sel_i[0]) begin
            forced_amp_sel_r <= wb_dat_i[SEL_MSB:SEL_LSB];   // R6
        end
    end

    // gain selection
    assign sel_auto  = (forced_amp_sel_r == SEL_AUTO);
    // reserved selector codes still stop ranging and sit at 1x
    assign forced_gain = (forced_amp_sel_r == SEL_2X) ? SEG_2X :
                         (forced_amp_sel_r == SEL_4X) ? SEG_4X :
                         (forced_amp_sel_r == SEL_8X) ? SEG_8X : SEG_1X;   // R8 R10
    // highest gain that keeps the amplified level inside full scale
    assign auto_pick = (amp_level < THR_8X) ? SEG_8X :
                       (amp_level < THR_4X) ? SEG_4X :
                       (amp_level < THR_2X) ? SEG_2X : SEG_1X;   // R7
    assign range_gain_nxt = !sel_auto ? forced_gain :   // R9
                            amp_valid ? auto_pick : range_gain_r;   // R7

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            range_gain_r <= SEG_1X;
            auto_range_r <= 1'b1;
        end else begin
            range_gain_r <= range_gain_nxt;
            auto_range_r <= sel_auto;   // R9
        end
    end

    seg_offset_add u_add (
        .clk         (clk),
        .rstn        (rstn),
        .in_valid    (adc_valid),
        .in_data     (adc_data),
        .in_seg      (adc_seg),
        .ofs_a       (cal_r[0]),
        .ofs_b       (cal_r[1]),
        .ofs_c       (cal_r[2]),
        .out_valid_r (corr_valid),
        .out_data_r  (corr_data)
    );   // R5

    assign wb_ack_o   = ack_r;
    assign wb_dat_o   = dat_r;
    assign range_gain = range_gain_r;
    assign auto_range = auto_range_r;
endmodule

// ==== design/gain_seg_pkg.sv ====
// Operation
// R1 - three read-only 8-bit offsets, reset zero
// R2 - offsets are signed; second serves 2x
// R3 - calibration completion loads all three offsets
// R4 - host should not write the offsets
// R5 - active segment offset added to converter output
// R6 - 3-bit selector at bits 5:3, reset zero
// R7 - selector 000 gives automatic amplitude ranging
// R8 - 001..100 force gain 1x, 2x, 4x, 8x
// R9 - non-normal selector switches automatic ranging off
// R10 - reserved bits read zero; 101..111 reserved
package gain_seg_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CAL_A  = 6'h0E;
    localparam logic [5:0] IDX_CAL_B  = 6'h0F;
    localparam logic [5:0] IDX_CAL_C  = 6'h10;
    localparam logic [5:0] IDX_FORCED = 6'h14;

    localparam int         NUM_CAL    = 3;
    localparam logic [7:0] CAL_RESET  = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // forced_amp_sel field of forced_amp_ctrl
    localparam int         SEL_LSB    = 3;
    localparam int         SEL_MSB    = 5;
    localparam logic [2:0] SEL_AUTO   = 3'h0;
    localparam logic [2:0] SEL_1X     = 3'h1;
    localparam logic [2:0] SEL_2X     = 3'h2;
    localparam logic [2:0] SEL_4X     = 3'h3;
    localparam logic [2:0] SEL_8X     = 3'h4;

    // converter word and ranging thresholds on the unamplified level
    localparam int          ADC_W     = 13;
    localparam logic [12:0] ADC_MAX   = 13'h1FFF;
    localparam logic [12:0] THR_8X    = 13'h0400;
    localparam logic [12:0] THR_4X    = 13'h0800;
    localparam logic [12:0] THR_2X    = 13'h1000;

    typedef enum logic [1:0] {SEG_1X, SEG_2X, SEG_4X, SEG_8X} gain_seg_type;

endpackage

// ==== design/seg_offset_add.sv ====
`timescale 1ns/1ps
module seg_offset_add (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // converter samples
    input  wire logic                      in_valid,
    input  wire logic [12:0]               in_data,
    input  gain_seg_pkg::gain_seg_type     in_seg,
    // calibration offsets
    input  wire logic [7:0]                ofs_a,
    input  wire logic [7:0]                ofs_b,
    input  wire logic [7:0]                ofs_c,
    // corrected samples
    output logic                           out_valid_r,
    output logic [12:0]                    out_data_r
);
    import gain_seg_pkg::*;

    logic [7:0]  ofs_sel;
    logic [14:0] sum;
    logic [12:0] sat;

    // 8x is the reference segment and carries no offset
    assign ofs_sel = (in_seg == SEG_4X) ? ofs_a :
                     (in_seg == SEG_2X) ? ofs_b :   // R2
                     (in_seg == SEG_1X) ? ofs_c : 8'h00;
    assign sum = {2'b00, in_data} + {{7{ofs_sel[7]}}, ofs_sel};   // R2
    // clip rather than wrap, a wrapped code would look like a flash artifact
    assign sat = sum[14] ? 13'h0000 : (sum[13] ? ADC_MAX : sum[12:0]);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_valid_r <= 1'b0;
            out_data_r  <= 13'h0000;
        end else begin
            out_valid_r <= in_valid;
            if (in_valid) begin
                out_data_r <= sat;   // R5
            end
        end
    end
endmodule

// ==== bench/gain_seg_checker.sv ====
`timescale 1ns/1ps
module gain_seg_checker (
    // clock, reset and bus
    input wire logic                 clk,
    input wire logic                 rstn,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic [7:0]           wb_adr_i,
    input wire logic [31:0]          wb_dat_o,
    input wire logic                 wb_ack_o,
    // data path and gain
    input wire logic                 adc_valid,
    input wire logic                 corr_valid,
    input wire logic [12:0]          corr_data,
    input wire logic                 auto_range,
    input gain_seg_pkg::gain_seg_type range_gain
);
    import gain_seg_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // a control read answer shows the selector that drives the gain
    wire ctl_rd = wb_ack_o && !wb_we_i && wb_adr_i == {IDX_FORCED, 2'h0};
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not answered");
    property p_no_req; !wb_cyc_i ##1 !wb_cyc_i |-> !wb_ack_o; endproperty
    a_no_req: assert property (p_no_req) else $error("ack without request");
    property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
    property p_resv; ctl_rd |-> wb_dat_o[7:6] == 2'h0 && wb_dat_o[2:0] == 3'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");
    property p_corr; adc_valid |=> corr_valid; endproperty
    a_corr: assert property (p_corr) else $error("sample result missing");
    property p_idle; !adc_valid |=> !corr_valid && $stable(corr_data); endproperty
    a_idle: assert property (p_idle) else $error("result moved without sample");
    property p_mode; ctl_rd |-> auto_range == (wb_dat_o[5:3] == 3'h0); endproperty
    a_mode: assert property (p_mode) else $error("ranging mode wrong");
    property p_forced;
        ctl_rd && wb_dat_o[5:3] inside {[3'h1:3'h4]}
            |-> range_gain == gain_seg_type'(wb_dat_o[4:3] - 2'h1);
    endproperty
    a_forced: assert property (p_forced) else $error("forced gain wrong");
endmodule
bind gain_seg_regs gain_seg_checker chk (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .adc_valid, .corr_valid, .corr_data, .auto_range,
    .range_gain);

// ==== bench/gain_seg_regs_bench.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module gain_seg_regs_bench;
    import gain_seg_pkg::*;
    logic         clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, cal = 0, amp_v = 0, adc_v = 0;
    logic [7:0]   adr = 0, wa = 0, wb = 0, wc = 0;
    logic [3:0]   sel = 4'hF;
    logic [31:0]  dati = 0, dato, rd, r;
    logic         ack, auto_r, corr_v;
    logic [12:0]  amp = 0, adc = 0, corr, pexp;
    gain_seg_type seg = SEG_1X, rg;
    logic [7:0]   ads [5] = '{8'h38, 8'h3C, 8'h40, 8'h50, 8'h44};
    logic [12:0]  lvl [4] = '{13'h03FF, 13'h0400, 13'h0FFF, 13'h1000};
    integer       seed = 32'hc3034bac, fails = 0, n_checks = 0, i, k;
    gain_seg_regs uut (.clk, .rstn, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack),
        .cal_done(cal), .seg_cal_word_a(wa), .seg_cal_word_b(wb), .seg_cal_word_c(wc),
        .amp_valid(amp_v), .amp_level(amp), .range_gain(rg), .auto_range(auto_r),
        .adc_valid(adc_v), .adc_data(adc), .adc_seg(seg), .corr_valid(corr_v),
        .corr_data(corr));
    initial forever #10 clk = ~clk;
    task end_sim;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer t;
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dati <= d;
        t = 0;
        do begin @(posedge clk); t++; end while (ack !== 1'b1 && t < 20);
        if (ack !== 1'b1) begin fails++; end_sim; end
        rd = dato;
        cyc <= 0; stb <= 0; we <= 0;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] ex);
        xfer(0, a, 0);
        `CHK("read", ex, rd)
    endtask
    function logic [12:0] cexp(logic [12:0] d, gain_seg_type s);
        integer v;
        v = d;
        // the 8x segment has no offset of its own
        case (s)
            SEG_4X: v += $signed(wa);
            SEG_2X: v += $signed(wb);
            SEG_1X: v += $signed(wc);
            default: ;
        endcase
        cexp = v < 0 ? 13'h0 : v > 8191 ? 13'h1FFF : v[12:0];
    endfunction
    function gain_seg_type pick(logic [12:0] l);
        pick = l < THR_8X ? SEG_8X : l < THR_4X ? SEG_4X : l < THR_2X ? SEG_2X : SEG_1X;
    endfunction
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        #1;
        `CHK("rst gain", SEG_1X, rg)
        `CHK("rst auto", 1'b1, auto_r)
        `CHK("rst valid", 1'b0, corr_v)
        `CHK("rst corr", 13'h0000, corr)
        for (i = 0; i < 5; i++) rdchk(ads[i], 32'h0);
        for (i = 0; i < 3; i++) begin
            xfer(1, ads[i], $random(seed));
            rdchk(ads[i], 32'h0);
        end
        // reserved codes 101..111 must still stop ranging; they hold 1x
        for (k = 7; k >= 0; k--) begin
            xfer(1, 8'h50, ($random(seed) & 32'hFFFFFFC7) | (k << 3));
            rdchk(8'h50, k << 3);
            @(posedge clk);
            #1;
            `CHK("auto", k == 0, auto_r)
            if (k != 0) `CHK("gain", k > 4 ? SEG_1X : gain_seg_type'(k - 1), rg)
        end
        // a write with the low byte lane off must not touch the selector
        @(posedge clk);
        sel <= 4'hE;
        xfer(1, 8'h50, 32'h20);
        sel <= 4'hF;
        rdchk(8'h50, 32'h0);
        for (i = 0; i < 24; i++) begin
            r = $random(seed);
            @(posedge clk);
            amp <= i < 4 ? lvl[i] : r[12:0];
            amp_v <= 1;
            @(posedge clk);
            amp_v <= 0;
            #1;
            `CHK("range", pick(amp), rg)
        end
        for (k = 0; k < 2; k++) begin
            r = $random(seed);
            // second pass pins the extremes of the signed offsets
            r = k ? 32'h807F01 : r;
            @(posedge clk);
            {wa, wb, wc} <= r[23:0];
            cal <= 1;
            @(posedge clk);
            cal <= 0;
            for (i = 0; i < 3; i++) rdchk(ads[i], {24'h0, r[23 - 8 * i -: 8]});
            for (i = 0; i <= 40; i++) begin
                r = $random(seed);
                @(posedge clk);
                adc_v <= i < 40;
                adc <= i == 0 ? 13'h0 : i == 1 ? 13'h1FFF : r[12:0];
                seg <= i == 0 ? SEG_4X : i == 1 ? SEG_2X : gain_seg_type'(r[14:13]);
                #1;
                if (i > 0) `CHK("corr", pexp, corr)
                pexp = cexp(adc, seg);
            end
        end
        end_sim;
    end
endmodule
